/* File: hdl/dmacam_pkg.sv */
package dmacam_pkg;
  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CUR_ADDR = 8'h00; // +8*ch
  localparam logic [7:0] ADDR_CUR_CNT = 8'h04;  // +8*ch
  localparam logic [7:0] ADDR_COMMAND = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;
  localparam logic [7:0] ADDR_MASK_SINGLE = 8'h28;
  localparam logic [7:0] ADDR_MASK_CLEAR = 8'h2C;
  localparam logic [7:0] ADDR_MASTER_CLEAR = 8'h30;
  localparam logic [7:0] ADDR_PTR_CLEAR = 8'h34;
  localparam logic [7:0] ADDR_MODE = 8'h38;
  localparam logic [7:0] ADDR_POLARITY = 8'h3C;
  localparam logic [7:0] ADDR_TC_STATUS = 8'h40;
  localparam int CH_STRIDE_SHIFT = 3;
  localparam int NUM_CH = 4;
  // ==========================================================
  // Field positions and reset values
  localparam int CMD_MEM2MEM_BIT = 0;
  localparam int CMD_ADDR_HOLD_BIT = 1;
  localparam int MODE_AUTOINIT_BIT = 4;
  localparam int MODE_DECREMENT_BIT = 5;
  localparam int MASK_SINGLE_SET_BIT = 2;
  localparam int POL_REQ_LOW_BIT = 0;
  localparam int POL_ACK_HIGH_BIT = 1;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'hF;
  localparam logic [3:0] MASK_READ_PAD = 4'hF;
  localparam logic [15:0] CNT_WRAP = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dmacam_pkg

/* File: hdl/dmacam_top.sv */
`timescale 1ns/1ps
module dmacam_top
  import dmacam_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic [3:0] CHANNEL_REQUEST_IN,
  input wire logic [3:0] XFER_DONE_IN,
  input wire logic [3:0] END_OF_PROCESS_IN,
  output logic [3:0] CHANNEL_REQUEST_GATED_OUT,
  output logic [3:0] CHANNEL_ACKNOWLEDGE_OUT,
  output logic [3:0] TERMINAL_COUNT_OUT,
  output logic [15:0] XFER_ADDR_OUT,
  output logic [7:0] COMMAND_OUT
);
  // ==========================================================
  // Register state
  logic [15:0] base_addr_r [NUM_CH];
  logic [15:0] base_cnt_r [NUM_CH];
  logic [15:0] cur_addr_r [NUM_CH];
  logic [15:0] cur_cnt_r [NUM_CH];
  logic [5:0] mode_r [NUM_CH];
  logic [7:0] command_r;
  logic [3:0] mask_r;
  logic byte_ptr_r;
  logic [1:0] polarity_r;
  logic [3:0] tc_r;
  logic [3:0] tc_stat_r;
  // ==========================================================
  // AXI4-Lite write channel
  logic aw_held_r, w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic [7:0] wa;
  logic [7:0] wb;
  logic mclr;
  logic wr_hit;
  assign wr_go = aw_held_r && w_held_r && !S_AXI_BVALID_OUT;
  assign wa = awaddr_r;
  assign wb = wstrb_r[0] ? wdata_r[7:0] : 8'h00;
  assign mclr = wr_go && wa == ADDR_MASTER_CLEAR;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_held_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR_IN;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_held_r <= 1'b1;
        wdata_r <= S_AXI_WDATA_IN;
        wstrb_r <= S_AXI_WSTRB_IN;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT <= 1'b0;
    end else begin
      S_AXI_AWREADY_OUT <= !aw_held_r && !S_AXI_AWREADY_OUT
        && S_AXI_AWVALID_IN && !S_AXI_BVALID_OUT;
      S_AXI_WREADY_OUT <= !w_held_r && !S_AXI_WREADY_OUT
        && S_AXI_WVALID_IN && !S_AXI_BVALID_OUT;
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    if (wa < ADDR_COMMAND && wa[1:0] == 2'h0) wr_hit = 1'b1;
    if (wa >= ADDR_COMMAND && wa <= ADDR_POLARITY && wa[1:0] == 2'h0)
      wr_hit = 1'b1;
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // ==========================================================
  // Decode of channel byte accesses
  logic wr_chan, rd_chan;
  logic [1:0] wch, rch;
  logic wr_is_cnt, rd_is_cnt;
  logic rd_go;
  logic [7:0] ra_r;
  assign wch = wa[4:3];
  assign wr_is_cnt = wa[2];
  assign wr_chan = wr_go && wa < ADDR_COMMAND && wa[1:0] == 2'h0;
  assign rch = ra_r[4:3];
  assign rd_is_cnt = ra_r[2];

  // ==========================================================
  // Byte pointer shared by all 16-bit accesses
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || mclr) begin
      byte_ptr_r <= 1'b0;
    end else if (wr_go && wa == ADDR_PTR_CLEAR) begin
      byte_ptr_r <= 1'b0;
    end else if (wr_chan || (rd_go && rd_chan)) begin
      byte_ptr_r <= !byte_ptr_r;
    end
  end

  // ==========================================================
  // Command and polarity
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || mclr) begin
      command_r <= CMD_RESET;
    end else if (wr_go && wa == ADDR_COMMAND) begin
      command_r <= wb;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      polarity_r <= 2'h0;
    end else if (wr_go && wa == ADDR_POLARITY) begin
      polarity_r <= wb[1:0];
    end
  end

  // ==========================================================
  // Mask
  logic [3:0] eop_ev;
  logic [3:0] no_auto;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || mclr) begin
      mask_r <= MASK_RESET;
    end else begin
      if (wr_go && wa == ADDR_MASK) begin
        mask_r <= wb[3:0];
      end else if (wr_go && wa == ADDR_MASK_CLEAR) begin
        mask_r <= 4'h0;
      end else if (wr_go && wa == ADDR_MASK_SINGLE) begin
        mask_r[wb[1:0]] <= wb[MASK_SINGLE_SET_BIT];
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (eop_ev[i] && no_auto[i]) mask_r[i] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Per-channel counters
  logic [3:0] req_act;
  logic [3:0] cnt_wrap;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic hold;
      assign no_auto[g] = !mode_r[g][MODE_AUTOINIT_BIT];
      assign hold = (g == 0) && command_r[CMD_MEM2MEM_BIT]
        && command_r[CMD_ADDR_HOLD_BIT];
      assign cnt_wrap[g] = XFER_DONE_IN[g] && cur_cnt_r[g] == 16'h0000;
      assign eop_ev[g] = cnt_wrap[g] || END_OF_PROCESS_IN[g];
      assign req_act[g] = CHANNEL_REQUEST_IN[g]
        ^ polarity_r[POL_REQ_LOW_BIT];

      always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
          mode_r[g] <= 6'h00;
        end else if (wr_go && wa == ADDR_MODE && wb[1:0] == 2'(g)) begin
          mode_r[g] <= wb[7:2];
        end
      end

      always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
          base_addr_r[g] <= 16'h0000;
          cur_addr_r[g] <= 16'h0000;
        end else if (wr_chan && wch == 2'(g) && !wr_is_cnt) begin
          if (byte_ptr_r) begin
            base_addr_r[g][15:8] <= wb;
            cur_addr_r[g][15:8] <= wb;
          end else begin
            base_addr_r[g][7:0] <= wb;
            cur_addr_r[g][7:0] <= wb;
          end
        end else if (eop_ev[g] && !no_auto[g]) begin
          cur_addr_r[g] <= base_addr_r[g];
        end else if (XFER_DONE_IN[g] && !hold) begin
          if (mode_r[g][MODE_DECREMENT_BIT])
            cur_addr_r[g] <= cur_addr_r[g] - 16'h0001;
          else
            cur_addr_r[g] <= cur_addr_r[g] + 16'h0001;
        end
      end

      always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
          base_cnt_r[g] <= 16'h0000;
          cur_cnt_r[g] <= 16'h0000;
        end else if (wr_chan && wch == 2'(g) && wr_is_cnt) begin
          if (byte_ptr_r) begin
            base_cnt_r[g][15:8] <= wb;
            cur_cnt_r[g][15:8] <= wb;
          end else begin
            base_cnt_r[g][7:0] <= wb;
            cur_cnt_r[g][7:0] <= wb;
          end
        end else if (eop_ev[g] && !no_auto[g]) begin
          cur_cnt_r[g] <= base_cnt_r[g];
        end else if (XFER_DONE_IN[g]) begin
          cur_cnt_r[g] <= cur_cnt_r[g] - 16'h0001;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Terminal count, status and pin outputs
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || mclr) begin
      tc_r <= 4'h0;
      tc_stat_r <= 4'h0;
    end else begin
      tc_r <= cnt_wrap;
      tc_stat_r <= (rd_go && ra_r == ADDR_TC_STATUS) ? cnt_wrap
        : (tc_stat_r | cnt_wrap);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      CHANNEL_REQUEST_GATED_OUT <= 4'h0;
      CHANNEL_ACKNOWLEDGE_OUT <= 4'h0;
      TERMINAL_COUNT_OUT <= 4'h0;
      XFER_ADDR_OUT <= 16'h0000;
      COMMAND_OUT <= CMD_RESET;
    end else begin
      CHANNEL_REQUEST_GATED_OUT <= req_act & ~mask_r;
      CHANNEL_ACKNOWLEDGE_OUT <= (XFER_DONE_IN & req_act)
        ^ {NUM_CH{!polarity_r[POL_ACK_HIGH_BIT]}};
      TERMINAL_COUNT_OUT <= tc_r;
      XFER_ADDR_OUT <= cur_addr_r[0];
      COMMAND_OUT <= command_r;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic ar_held_r;
  logic [7:0] rdat;
  logic rd_hit;
  assign rd_go = ar_held_r && !S_AXI_RVALID_OUT;
  assign rd_chan = ra_r < ADDR_COMMAND && ra_r[1:0] == 2'h0;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ar_held_r <= 1'b0;
      ra_r <= 8'h00;
      S_AXI_ARREADY_OUT <= 1'b0;
    end else begin
      S_AXI_ARREADY_OUT <= !ar_held_r && !S_AXI_ARREADY_OUT
        && S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT;
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
        ar_held_r <= 1'b1;
        ra_r <= S_AXI_ARADDR_IN;
      end else if (rd_go) begin
        ar_held_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rdat = 8'h00;
    rd_hit = 1'b1;
    if (rd_chan) begin
      // Base copies have no read path
      if (rd_is_cnt)
        rdat = byte_ptr_r ? cur_cnt_r[rch][15:8] : cur_cnt_r[rch][7:0];
      else
        rdat = byte_ptr_r ? cur_addr_r[rch][15:8] : cur_addr_r[rch][7:0];
    end else if (ra_r == ADDR_COMMAND) begin
      rdat = command_r;
    end else if (ra_r == ADDR_MASK) begin
      rdat = {MASK_READ_PAD, mask_r};
    end else if (ra_r == ADDR_POLARITY) begin
      rdat = {6'h00, polarity_r};
    end else if (ra_r == ADDR_TC_STATUS) begin
      rdat = {4'h0, tc_stat_r};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h00000000;
      S_AXI_RRESP_OUT <= RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RDATA_OUT <= {24'h000000, rdat};
      S_AXI_RRESP_OUT <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  a_cmd_clear: assert property (mclr |=> command_r == CMD_RESET)
    else $error("command not cleared");
  a_mask_set: assert property (mclr |=> mask_r == MASK_RESET)
    else $error("mask not set by clear");
  a_mask_clr_all: assert property (wr_go && wa == ADDR_MASK_CLEAR
    && eop_ev == 4'h0 |=> mask_r == 4'h0)
    else $error("mask not cleared");
  a_req_gate: assert property (mask_r[0] |=>
    !CHANNEL_REQUEST_GATED_OUT[0])
    else $error("masked request passed");
  a_tc_wrap: assert property (cnt_wrap[1] && !wr_chan && no_auto[1] && !mclr
    |=> cur_cnt_r[1] == CNT_WRAP ##1 TERMINAL_COUNT_OUT[1])
    else $error("wrap without terminal count");
  a_auto_mask: assert property (eop_ev[2] && no_auto[2] && !mclr
    |=> mask_r[2])
    else $error("end did not mask channel");
  a_auto_reload: assert property (eop_ev[3] && !no_auto[3] && !wr_chan
    |=> cur_addr_r[3] == $past(base_addr_r[3]))
    else $error("autoinit reload missing");
  a_addr_hold: assert property (XFER_DONE_IN[0] && g_ch[0].hold
    && !eop_ev[0] && !wr_chan |=> $stable(cur_addr_r[0]))
    else $error("held address moved");
  a_addr_step: assert property (XFER_DONE_IN[1] && !eop_ev[1] && !wr_chan
    && !mode_r[1][MODE_DECREMENT_BIT]
    |=> cur_addr_r[1] == $past(cur_addr_r[1]) + 16'h0001)
    else $error("address did not step");
  a_mask_read: assert property (rd_go && ra_r == ADDR_MASK
    |=> S_AXI_RDATA_OUT[7:4] == MASK_READ_PAD)
    else $error("mask read pad wrong");
  a_ptr_toggle: assert property (wr_chan && !mclr
    |=> byte_ptr_r != $past(byte_ptr_r))
    else $error("byte pointer stuck");

  c_write: cover property (wr_go ##[1:8] S_AXI_BVALID_OUT);
  c_read_mask: cover property (rd_go && ra_r == ADDR_MASK);
  c_wrap: cover property (cnt_wrap != 4'h0);
  c_autoinit: cover property (eop_ev[0] && !no_auto[0]);
endmodule : dmacam_top

/* File: testbench/dmacam_periph_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Requesting peripheral: holds request until acknowledged
module dmacam_periph_model (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [3:0] go_in,
  input wire logic req_low_in,
  input wire logic ack_high_in,
  input wire logic [3:0] ack_in,
  output logic [3:0] req_out
);
  logic [3:0] pend_r;
  logic [3:0] ack_act;

  assign ack_act = ack_high_in ? ack_in : ~ack_in;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pend_r <= 4'h0;
    end else begin
      pend_r <= (pend_r | go_in) & ~ack_act;
    end
  end
  assign req_out = req_low_in ? ~pend_r : pend_r;
endmodule : dmacam_periph_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import dmacam_pkg::*;
  localparam int GAP_CYC = 25;
  logic clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic req_low, ack_high;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0] bresp, rresp, rd_resp, wr_resp;
  logic [3:0] req, xdone, eop, gated, ack, tc, go;
  logic [15:0] xaddr;
  logic [7:0] cmd;
  int err_total, cmp_count, tc_cnt;

  dmacam_top dmacam_top_i (.CLK_IN(clk), .SRST_IN(srst),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'h1), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .CHANNEL_REQUEST_IN(req),
    .XFER_DONE_IN(xdone), .END_OF_PROCESS_IN(eop),
    .CHANNEL_REQUEST_GATED_OUT(gated),
    .CHANNEL_ACKNOWLEDGE_OUT(ack), .TERMINAL_COUNT_OUT(tc),
    .XFER_ADDR_OUT(xaddr), .COMMAND_OUT(cmd));

  dmacam_periph_model dmacam_periph_model_i (.clk_in(clk),
    .srst_in(srst), .go_in(go), .req_low_in(req_low),
    .ack_high_in(ack_high), .ack_in(ack), .req_out(req));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (tc !== 4'h0) begin
      tc_cnt++;
    end
  end

  // ==========================================================
  // Reporting
  task close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task hang;
    err_total++;
    close_out();
  endtask : hang

  // ==========================================================
  // Bus master
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (aw && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready === 1'b1) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 50);
    wr_resp = bresp;
    bready <= 1'b0;
    repeat (GAP_CYC) @(posedge clk);
    if (n >= 50) begin
      hang();
    end
  endtask : wr

  task rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && n < 50);
    rd_v = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    repeat (GAP_CYC) @(posedge clk);
    if (n >= 50) begin
      hang();
    end
  endtask : rd

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk({24'h0, rd_v[7:0]}, {24'h0, exp});
  endtask : rd_chk

  task xfer(input int ch);
    xdone <= 4'(1 << ch);
    @(posedge clk);
    xdone <= 4'h0;
    repeat (3) @(posedge clk);
  endtask : xfer

  // ==========================================================
  // Scenarios
  task t_reset;
    rd_chk(ADDR_MASK, 8'hFF);
    rd_chk(ADDR_COMMAND, 8'h00);
  endtask : t_reset

  task t_mask;
    wr(ADDR_MASK_CLEAR, 32'h0);
    rd_chk(ADDR_MASK, 8'hF0);
    wr(ADDR_MASK_SINGLE, 32'h6);
    rd_chk(ADDR_MASK, 8'hF4);
    wr(ADDR_MASK, 32'h0A);
    rd_chk(ADDR_MASK, 8'hFA);
    wr(ADDR_MASK_SINGLE, 32'h3);
    rd_chk(ADDR_MASK, 8'hF2);
    go <= 4'h2;
    @(posedge clk);
    go <= 4'h0;
    repeat (3) @(posedge clk);
    chk({28'h0, gated}, 32'h0);
    wr(ADDR_MASK_SINGLE, 32'h1);
    repeat (3) @(posedge clk);
    chk({28'h0, gated}, 32'h2);
  endtask : t_mask

  task t_count;
    wr(ADDR_PTR_CLEAR, 32'h0);
    wr(8'h08, 32'h34);
    wr(8'h08, 32'h12);
    wr(8'h0C, 32'h02);
    wr(8'h0C, 32'h00);
    rd_chk(8'h08, 8'h34);
    rd_chk(8'h08, 8'h12);
    tc_cnt = 0;
    xfer(1);
    xfer(1);
    chk(tc_cnt, 32'h0);
    xfer(1);
    chk(tc_cnt, 32'h1);
    chk({28'h0, req}, 32'h0);
    rd_chk(8'h0C, 8'hFF);
    rd_chk(8'h0C, 8'hFF);
    rd_chk(8'h08, 8'h37);
    rd_chk(8'h08, 8'h12);
    rd_chk(ADDR_MASK, 8'hF2);
  endtask : t_count

  task t_autoinit;
    wr(ADDR_MODE, 32'h42);
    wr(ADDR_PTR_CLEAR, 32'h0);
    wr(8'h10, 32'h10);
    wr(8'h10, 32'h00);
    wr(8'h14, 32'h00);
    wr(8'h14, 32'h00);
    wr(ADDR_MASK_CLEAR, 32'h0);
    xfer(2);
    rd_chk(8'h10, 8'h10);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h14, 8'h00);
    rd_chk(8'h14, 8'h00);
    eop <= 4'h8;
    @(posedge clk);
    eop <= 4'h0;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_MASK, 8'hF8);
  endtask : t_autoinit

  task t_hold;
    wr(ADDR_COMMAND, 32'h03);
    rd_chk(ADDR_COMMAND, 8'h03);
    wr(ADDR_PTR_CLEAR, 32'h0);
    wr(8'h00, 32'h55);
    wr(8'h00, 32'h00);
    xfer(0);
    xfer(0);
    chk({16'h0, xaddr}, 32'h55);
    wr(ADDR_MASTER_CLEAR, 32'h0);
    rd_chk(ADDR_COMMAND, 8'h00);
    chk({24'h0, cmd}, 32'h0);
    rd_chk(ADDR_MASK, 8'hFF);
    rd(8'h44);
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
    wr(ADDR_TC_STATUS, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
  endtask : t_hold

  task t_polar;
    wr(ADDR_POLARITY, 32'h3);
    chk({30'h0, wr_resp}, {30'h0, RESP_OKAY});
    req_low <= 1'b1;
    ack_high <= 1'b1;
    rd_chk(ADDR_POLARITY, 8'h03);
    chk({28'h0, ack}, 32'h0);
    wr(ADDR_MODE, 32'h83);
    wr(ADDR_PTR_CLEAR, 32'h0);
    wr(8'h18, 32'h00);
    wr(8'h18, 32'h01);
    wr(8'h1C, 32'h00);
    wr(8'h1C, 32'h00);
    wr(ADDR_MASK_CLEAR, 32'h0);
    go <= 4'h8;
    @(posedge clk);
    go <= 4'h0;
    repeat (3) @(posedge clk);
    chk({28'h0, gated}, 32'h8);
    xfer(3);
    chk({28'h0, req}, 32'hF);
    rd_chk(8'h18, 8'hFF);
    rd_chk(8'h18, 8'h00);
    rd_chk(ADDR_TC_STATUS, 8'h08);
    rd_chk(ADDR_TC_STATUS, 8'h00);
    rd_chk(ADDR_MASK, 8'hF8);
  endtask : t_polar

  initial begin
    err_total = 0;
    cmp_count = 0;
    tc_cnt = 0;
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    xdone = 4'h0;
    eop = 4'h0;
    go = 4'h0;
    req_low = 1'b0;
    ack_high = 1'b0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_mask();
    t_count();
    t_autoinit();
    t_hold();
    t_polar();
    close_out();
  end
endmodule : tb
